// File: design/frct_timer.sv
// Free running 16-bit counter with input capture latch and remote relay.
// Assumes host strobes are one-cycle and synchronous to sys_clk, inputs too.
`timescale 1ns/1ps
`default_nettype none
`include "frct_map.svh"

module frct_timer (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  io_addr,
    input  wire logic        io_rd,
    input  wire logic        io_wr,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    input  wire logic        capture_source_select,
    input  wire logic        tape_input,
    input  wire logic        scanner_input,
    input  wire logic        overflow_clear,
    output logic             overflow_flag,
    output logic             overflow_irq,
    output logic             capture_flag,
    output logic             remote_relay_flag,
    output logic      [15:0] free_running_counter,
    output logic      [15:0] capture_latch
);

    frct_pkg::frct_state_t st_reg;
    frct_pkg::frct_state_t st_next;
    logic                  tick;
    logic                  wrap;
    logic                  src_edge;
    logic                  rd_low;
    logic                  rd_high;

    frct_divider u_div (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .tick    (tick)
    );

    assign wrap    = tick && (st_reg.cnt == `FRCT_CNT_MAX);
    assign rd_low  = io_rd && (io_addr == `FRCT_PORT_CAPT_LOW);
    assign rd_high = io_rd && (io_addr == `FRCT_PORT_CAPT_HIGH);
    // Select high picks the scanner; low picks the tape input
    // Both previous levels are kept so a source switch makes no false edge
    assign src_edge = capture_source_select ?
                      (scanner_input != st_reg.scan_prev) :
                      (tape_input != st_reg.tape_prev);

    always_comb begin
        st_next = st_reg;
        st_next.tape_prev = tape_input;
        st_next.scan_prev = scanner_input;
        st_next.rdata     = `FRCT_READ_IDLE;
        // One step per tick; the 16-bit sum wraps to zero
        if (tick) begin
            st_next.cnt = st_reg.cnt + `FRCT_CNT_ONE;
        end
        // Overflow period is 65536 ticks of the divided clock
        // Software clear loses to a coincident wrap
        if (wrap) begin
            st_next.ovf_flag = 1'b1;
            st_next.ovf_irq  = 1'b1;
        end else if (overflow_clear) begin
            st_next.ovf_flag = 1'b0;
            st_next.ovf_irq  = 1'b0;
        end
        // Any access to the high byte clears the capture flag
        if (rd_high || (io_wr && io_addr == `FRCT_PORT_CAPT_HIGH)) begin
            st_next.capt_flag = 1'b0;
        end
        // Input edge latches and flags; set beats the clear above
        if (src_edge) begin
            st_next.latch     = st_reg.cnt;
            st_next.capt_flag = 1'b1;
        end
        // Port 0 read latches and returns the live low byte
        if (rd_low) begin
            st_next.latch = st_reg.cnt;
            st_next.rdata = st_reg.cnt[7:0];
        end
        // High byte comes from the latch, set by the last low read or input edge
        if (rd_high) begin
            st_next.rdata = st_reg.latch[15:8];
        end
        // Other written values leave the relay as it was
        if (io_wr && io_addr == `FRCT_PORT_REMOTE) begin
            if (io_wdata == `FRCT_REMOTE_CLOSE) begin
                st_next.relay = 1'b1;
            end else if (io_wdata == `FRCT_REMOTE_OPEN) begin
                st_next.relay = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign io_rdata             = st_reg.rdata;
    assign overflow_flag        = st_reg.ovf_flag;
    assign overflow_irq         = st_reg.ovf_irq;
    assign capture_flag         = st_reg.capt_flag;
    assign remote_relay_flag    = st_reg.relay;
    assign free_running_counter = st_reg.cnt;
    assign capture_latch        = st_reg.latch;

    // Checking helpers: cycles since last tick
    logic [7:0] gap_cnt;
    logic       seen_tick;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gap_cnt   <= 8'h00;
            seen_tick <= 1'b0;
        end else if (tick) begin
            gap_cnt   <= 8'h01;
            seen_tick <= 1'b1;
        end else begin
            gap_cnt   <= gap_cnt + 8'h01;
        end
    end

    sequence s_wrap;
        tick && st_reg.cnt == `FRCT_CNT_MAX;
    endsequence

    sequence s_low_read;
        io_rd && io_addr == `FRCT_PORT_CAPT_LOW;
    endsequence

    property p_count_step;
        @(posedge sys_clk) disable iff (!rstn)
        tick && st_reg.cnt != `FRCT_CNT_MAX |=>
            st_reg.cnt == $past(st_reg.cnt) + `FRCT_CNT_ONE;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not step on tick");

    property p_count_hold;
        @(posedge sys_clk) disable iff (!rstn)
        !tick |=> $stable(st_reg.cnt);
    endproperty
    a_count_hold: assert property (p_count_hold)
        else $error("counter moved without tick");

    property p_ovf_raise;
        @(posedge sys_clk) disable iff (!rstn)
        s_wrap |=> overflow_flag && overflow_irq;
    endproperty
    a_ovf_raise: assert property (p_ovf_raise)
        else $error("overflow flag or irq missing after wrap");

    property p_wrap_zero;
        @(posedge sys_clk) disable iff (!rstn)
        s_wrap |=> free_running_counter == `FRCT_CNT_RESET ##1
            !$rose(overflow_flag);
    endproperty
    a_wrap_zero: assert property (p_wrap_zero)
        else $error("wrap did not reach zero");

    property p_tick_period;
        @(posedge sys_clk) disable iff (!rstn)
        tick && seen_tick |-> gap_cnt == 8'(`FRCT_TICK_CYCLES);
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("tick spacing wrong");

    property p_low_read;
        @(posedge sys_clk) disable iff (!rstn)
        s_low_read |=> capture_latch == $past(st_reg.cnt) &&
            io_rdata == $past(st_reg.cnt[7:0]);
    endproperty
    a_low_read: assert property (p_low_read)
        else $error("low read did not latch counter");

    property p_tape_capture;
        @(posedge sys_clk) disable iff (!rstn)
        !capture_source_select && tape_input != st_reg.tape_prev |=>
            capture_flag && capture_latch == $past(st_reg.cnt);
    endproperty
    a_tape_capture: assert property (p_tape_capture)
        else $error("tape edge not captured");

    property p_scan_capture;
        @(posedge sys_clk) disable iff (!rstn)
        capture_source_select && scanner_input != st_reg.scan_prev |=>
            capture_flag && capture_latch == $past(st_reg.cnt);
    endproperty
    a_scan_capture: assert property (p_scan_capture)
        else $error("scanner edge not captured");

    property p_high_clear;
        @(posedge sys_clk) disable iff (!rstn)
        rd_high && !src_edge |=> !capture_flag;
    endproperty
    a_high_clear: assert property (p_high_clear)
        else $error("capture flag not cleared by high access");

    property p_high_read;
        @(posedge sys_clk) disable iff (!rstn)
        s_low_read ##1 rd_high |=> io_rdata == $past(st_reg.cnt[15:8], 2);
    endproperty
    a_high_read: assert property (p_high_read)
        else $error("high byte does not pair with low read");

    property p_relay;
        @(posedge sys_clk) disable iff (!rstn)
        io_wr && io_addr == `FRCT_PORT_REMOTE |=>
            ($past(io_wdata) == `FRCT_REMOTE_CLOSE) ? remote_relay_flag :
            ($past(io_wdata) == `FRCT_REMOTE_OPEN) ? !remote_relay_flag :
            remote_relay_flag == $past(remote_relay_flag);
    endproperty
    a_relay: assert property (p_relay)
        else $error("relay did not follow port write");

endmodule
`default_nettype wire

// File: pkg/frct_map.svh
// Constants of the free running capture timer: I/O ports, values, timing.
// Assumes a 100 MHz system clock and an 8-bit host I/O strobe interface.
`ifndef FRCT_MAP_SVH
`define FRCT_MAP_SVH

`define FRCT_PORT_CAPT_LOW   8'h00
`define FRCT_PORT_CAPT_HIGH  8'h01
`define FRCT_PORT_REMOTE     8'h02
`define FRCT_REMOTE_CLOSE    8'h02
`define FRCT_REMOTE_OPEN     8'h00
`define FRCT_READ_IDLE       8'h00

`define FRCT_CNT_MAX         16'hFFFF
`define FRCT_CNT_RESET       16'h0000
`define FRCT_CNT_ONE         16'h0001
`define FRCT_LATCH_RESET     16'h0000

`define FRCT_CLK_PERIOD_NS   10
`define FRCT_OVF_PERIOD_NS   106667000
`define FRCT_CNT_STATES      65536
`define FRCT_TICK_CYCLES     (`FRCT_OVF_PERIOD_NS / `FRCT_CNT_STATES \
                              / `FRCT_CLK_PERIOD_NS)
`define FRCT_TICK_LAST       8'(`FRCT_TICK_CYCLES - 1)
`define FRCT_DIV_RESET       8'h00
`define FRCT_DIV_ONE         8'h01

`endif

// File: pkg/frct_pkg.sv
// Types of the free running capture timer.
// Widths follow the 16-bit counter and 8-bit host data bus.
`default_nettype none
package frct_pkg;

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] latch;
        logic        ovf_flag;
        logic        ovf_irq;
        logic        capt_flag;
        logic        relay;
        logic        tape_prev;
        logic        scan_prev;
        logic [7:0]  rdata;
    } frct_state_t;

    typedef struct packed {
        logic [7:0] count;
        logic       tick;
    } frct_div_state_t;

endpackage
`default_nettype wire

// File: design/frct_divider.sv
// Divider producing the counter's tick enable from the system clock.
// Assumes one clock domain; the tick is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "frct_map.svh"

module frct_divider (
    input  wire logic sys_clk,
    input  wire logic rstn,
    output logic      tick
);

    frct_pkg::frct_div_state_t st_reg;
    frct_pkg::frct_div_state_t st_next;

    // Free running, no software enable needed
    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.count == `FRCT_TICK_LAST) begin
            st_next.count = `FRCT_DIV_RESET;
            st_next.tick  = 1'b1;
        end else begin
            st_next.count = st_reg.count + `FRCT_DIV_ONE;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;

endmodule
`default_nettype wire

// File: bench/frct_host.sv
// Host CPU model: strobed I/O port reads and writes to the timer.
// Assumes the timer samples on rising edges; drives on falling edges.
`timescale 1ns/1ps
`default_nettype none
module frct_host (
    input  wire logic       sys_clk,
    input  wire logic [7:0] io_rdata,
    output var  logic [7:0] io_addr,
    output var  logic       io_rd,
    output var  logic       io_wr,
    output var  logic [7:0] io_wdata
);
    initial begin
        io_addr  = 8'h5A;
        io_rd    = 1'b0;
        io_wr    = 1'b0;
        io_wdata = 8'hA5;
    end

    // One strobe held across one sampling edge; read data stands one cycle
    task automatic xfer(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
        @(negedge sys_clk);
        io_addr  = a;
        io_wdata = d;
        io_rd    = !w;
        io_wr    = w;
        @(negedge sys_clk);
        q        = io_rdata;
        io_rd    = 1'b0;
        io_wr    = 1'b0;
        // Released bus shows no stale value
        io_addr  = ~a;
        io_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// Testbench: host model and bench drive the capture timer, check ports.
// Assumes 100 MHz sys_clk; inputs change on falling edges only.
`timescale 1ns/1ps
`default_nettype none
`include "frct_map.svh"
module tb;
    localparam int TICK = `FRCT_TICK_CYCLES;
    logic        sys_clk;
    logic        rstn;
    logic [7:0]  io_addr;
    logic        io_rd;
    logic        io_wr;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic        capture_source_select;
    logic        tape_input;
    logic        scanner_input;
    logic        overflow_clear;
    logic        overflow_flag;
    logic        overflow_irq;
    logic        capture_flag;
    logic        remote_relay_flag;
    logic [15:0] free_running_counter;
    logic [15:0] capture_latch;
    logic [7:0]  q;
    logic [15:0] e;
    int          n_fail = 0;
    int          check_count = 0;
    int          cyc = 0;
    wire  logic [15:0] flags = {12'h000, overflow_flag, overflow_irq,
                                capture_flag, remote_relay_flag};

    frct_timer i_frct_timer (.sys_clk, .rstn, .io_addr, .io_rd, .io_wr,
        .io_wdata, .io_rdata, .capture_source_select, .tape_input,
        .scanner_input, .overflow_clear, .overflow_flag, .overflow_irq,
        .capture_flag, .remote_relay_flag, .free_running_counter,
        .capture_latch);
    frct_host i_frct_host (.sys_clk, .io_rdata, .io_addr, .io_rd, .io_wr,
        .io_wdata);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (rstn) cyc <= cyc + 1;

    task automatic chk(input string nm, input logic [15:0] ex, gt);
        check_count++;
        if (gt !== ex) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, ex, gt);
        end
    endtask
    // Mid-period sampling keeps the divider phase out of the expectation
    task automatic mid;
        do @(negedge sys_clk); while (cyc % TICK != TICK / 2);
        e = 16'(cyc / TICK);
    endtask
    task automatic io(input logic w, input logic [7:0] a, d);
        i_frct_host.xfer(w, a, d, q);
    endtask
    task automatic edge_chk(input logic tp, input logic [15:0] ex);
        mid;
        if (tp) tape_input = ~tape_input;
        else scanner_input = ~scanner_input;
        @(negedge sys_clk);
        chk("latch", ex == 16'h0000 ? e : e - 16'h0001, capture_latch);
    endtask

    task automatic t_reset;
        chk("counter", 16'h0000, free_running_counter);
        chk("latch", 16'h0000, capture_latch);
        chk("flags", 16'h0000, flags);
        chk("rdata", 16'h0000, {8'h00, io_rdata});
        $display("test reset done");
    endtask
    task automatic t_count;
        repeat (3) begin
            mid;
            chk("counter", e, free_running_counter);
        end
        overflow_clear = 1'b1; // Software clear of a quiet flag
        @(negedge sys_clk);
        overflow_clear = 1'b0;
        chk("flags", 16'h0000, flags);
        $display("test count done");
    endtask
    task automatic t_capture;
        io(1'b1, 8'h02, 8'h02); // Relay closed before tape use
        chk("relay", 16'h0001, {15'h0000, remote_relay_flag});
        capture_source_select = 1'b0; // One source at a time
        edge_chk(1'b1, 16'h0000);
        chk("cflag", 16'h0001, {15'h0000, capture_flag});
        edge_chk(1'b0, 16'h0001);
        io(1'b0, 8'h01, 8'h00);
        chk("rdata", (e - 16'h0001) >> 8, {8'h00, q});
        chk("cflag", 16'h0000, {15'h0000, capture_flag});
        capture_source_select = 1'b1;
        edge_chk(1'b0, 16'h0000);
        chk("cflag", 16'h0001, {15'h0000, capture_flag});
        edge_chk(1'b1, 16'h0001);
        io(1'b1, 8'h01, 8'h00); // A write counts as access
        chk("cflag", 16'h0000, {15'h0000, capture_flag});
        $display("test capture done");
    endtask
    task automatic t_relay;
        // Relay enters closed, so open first; the 05 writes check that it holds
        io(1'b1, 8'h02, 8'h00);
        chk("relay", 16'h0000, {15'h0000, remote_relay_flag});
        io(1'b1, 8'h02, 8'h05);
        chk("relay", 16'h0000, {15'h0000, remote_relay_flag});
        io(1'b1, 8'h02, 8'h02);
        chk("relay", 16'h0001, {15'h0000, remote_relay_flag});
        io(1'b1, 8'h02, 8'h05);
        chk("relay", 16'h0001, {15'h0000, remote_relay_flag});
        io(1'b0, 8'h03, 8'h00);
        chk("rdata", 16'h0000, {8'h00, q});
        $display("test relay done");
    endtask
    task automatic t_read;
        // Late enough that the high byte is no longer zero
        wait (cyc > 42000);
        mid;
        io(1'b0, 8'h00, 8'h00);
        chk("rdata", {8'h00, e[7:0]}, {8'h00, q});
        chk("latch", e, capture_latch);
        io(1'b0, 8'h01, 8'h00);
        chk("rdata", {8'h00, e[15:8]}, {8'h00, q});
        $display("test read done");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        n_fail++;
        summarize;
    end
    initial begin
        rstn = 1'b0;
        capture_source_select = 1'b1;
        tape_input = 1'b0;
        scanner_input = 1'b0;
        overflow_clear = 1'b0;
        repeat (20) @(negedge sys_clk);
        t_reset;
        rstn = 1'b1;
        t_count;
        t_capture;
        t_relay;
        t_read;
        summarize;
    end
endmodule
`default_nettype wire
